//--- hw/cpkd_map.svh
// constants of the configuration port key decoder
`ifndef CPKD_MAP_SVH
`define CPKD_MAP_SVH
// ****************************************
// keys and port layout
// ****************************************
`define CPKD_KEY_ENTER 8'h55
`define CPKD_KEY_EXIT 8'haa
`define CPKD_BASE_STRAP0 16'h002e
`define CPKD_BASE_STRAP1 16'h004e
`define CPKD_DATA_OFS 16'h0001
// ****************************************
// global register indices
// ****************************************
`define CPKD_IDX_CTRL 8'h02
`define CPKD_IDX_LDSEL 8'h07
`define CPKD_IDX_DEVID 8'h20
`define CPKD_IDX_DEVREV 8'h21
`define CPKD_IDX_BASE_LO 8'h26
`define CPKD_IDX_BASE_HI 8'h27
`define CPKD_IDX_ACTIVATE 8'h30
`define CPKD_IDX_LD_FIRST 8'h30
`define CPKD_CTRL_SOFT_BIT 0
`define CPKD_LD_COUNT 8
// ****************************************
// reset values
// ****************************************
`define CPKD_LDSEL_RST 8'h00
`define CPKD_ACTIVE_RST 8'h00
`define CPKD_DEVID_VAL 8'h5a // arbitrary identification value
`define CPKD_DEVREV_VAL 8'h01 // arbitrary revision value
// ****************************************
// timing
// ****************************************
`define CPKD_CLK_MHZ 50
`define CPKD_BLOCK_US 500
`define CPKD_BLOCK_CYCLES (`CPKD_BLOCK_US * `CPKD_CLK_MHZ)
`endif

//--- hw/cpkd_pkg.sv
// types of the configuration port key decoder
package cpkd_pkg;
  // decoder mode
  typedef enum logic [0:0] {
    CPKD_RUN = 1'b0,
    CPKD_CFG = 1'b1
  } cpkd_state_t;
  // source of the read data returned in the answer cycle
  typedef enum logic [1:0] {
    CPKD_SRC_NONE = 2'b00,
    CPKD_SRC_HELD = 2'b01,
    CPKD_SRC_MEM = 2'b10
  } cpkd_src_t;
endpackage

//--- hw/cpkd_cfg_mem.sv
// per logical device configuration byte store
`timescale 1ns/10ps
module cpkd_cfg_mem (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // access port
  input wire logic memWrite,
  input wire logic [10:0] memAddr,
  input wire logic [7:0] memWdata,
  output logic [7:0] memRdata
);
  // storage has no reset; only the read register is cleared
  logic [7:0] store [0:2047];
  // ****************************************
  // write port
  // ****************************************
  always_ff @(posedge clk) begin
    if (memWrite) begin
      store[memAddr] <= memWdata;
    end
  end
  // ****************************************
  // registered read port
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      memRdata <= 8'h00;
    end else begin
      memRdata <= store[memAddr];
    end
  end
endmodule // cpkd_cfg_mem

//--- hw/cpkd_top.sv
// configuration port key decoder with index and data ports
// Behaviour
// - power and host resets leave run mode, devices disabled; soft reset disables devices and clears bank select
// - strap sampled at host or power reset
// - strap low 0x002e, high 0x004e
// - base relocatable by two base registers
// - key 0x55 enters configuration mode
// - key 0xaa in configuration returns run
// - index and data ignored in run mode
// - index at base, data at base+1
// - index 0x07 selects logical device bank
// - data routed to indexed bank register
// - globals reachable without bank select
// - only two modes, run accepts entry
// - accesses blocked 500 us after power
`timescale 1ns/10ps
`include "cpkd_map.svh"
module cpkd_top #(
  parameter int BLOCK_CYCLES = `CPKD_BLOCK_CYCLES
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic reset_n,
  // pins from the board
  input wire logic host_bus_reset_n,
  input wire logic strapSelect,
  // decoded host i/o cycle
  input wire logic ioStrobe,
  input wire logic ioWrite,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWdata,
  // answer to the host cycle
  output logic ioAck,
  output logic [7:0] ioRdata,
  // decoder status
  output cpkd_pkg::cpkd_state_t cfgMode,
  output logic hostBlocked,
  output logic [15:0] cfgBase,
  output logic [7:0] ldSelect,
  output logic [7:0] ldActive
);
  import cpkd_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic hostRstMeta; // first stage, read only by the second
  logic hostRstSync; // synchronised host bus reset, low active
  logic hostRstPrev; // delayed copy for edge detection
  logic strapMeta; // first stage of strap sync
  logic strapSync; // synchronised strap level
  logic hostRstFall; // one cycle at host reset falling edge
  logic hostRstActive; // host bus reset held low

  // two flops per pin before any logic looks at it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hostRstMeta <= 1'b1;
      hostRstSync <= 1'b1;
      hostRstPrev <= 1'b1;
    end else begin
      hostRstMeta <= host_bus_reset_n;
      hostRstSync <= hostRstMeta;
      hostRstPrev <= hostRstSync;
    end
  end

  // strap level sync
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      strapMeta <= 1'b0;
      strapSync <= 1'b0;
    end else begin
      strapMeta <= strapSelect;
      strapSync <= strapMeta;
    end
  end

  assign hostRstFall = hostRstPrev & ~hostRstSync;
  assign hostRstActive = ~hostRstSync;

  // ****************************************
  // power-on strap catch and access block
  // ****************************************
  logic strapPending_reg; // strap still to be taken after power reset
  logic [15:0] blockCount_reg; // cycles left in the power-on block
  logic strapTake; // cycle in which the strap is applied

  // the strap cannot be loaded under reset, so it is taken when the block
  // count reaches two, after the synchronisers have filled
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      strapPending_reg <= 1'b1;
    end else if (blockCount_reg <= 16'h0002) begin
      strapPending_reg <= 1'b0;
    end
  end

  assign strapTake = (strapPending_reg && blockCount_reg <= 16'h0002) || hostRstFall;

  // countdown of the access block after power-on
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      blockCount_reg <= 16'(BLOCK_CYCLES);
    end else if (blockCount_reg != 16'h0000) begin
      blockCount_reg <= blockCount_reg - 16'h0001;
    end
  end

  // blocked flag goes out from a flop
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hostBlocked <= 1'b1;
    end else begin
      hostBlocked <= (blockCount_reg > 16'h0001);
    end
  end

  // ****************************************
  // address decode
  // ****************************************
  logic [7:0] index_reg; // last value written to the index port
  logic [15:0] dataAddr; // data port address
  logic take; // cycle accepted by the decoder
  logic hitBase; // access at the configuration/index port
  logic hitData; // access at the data port
  logic keyWrite; // write to the configuration port
  logic idxAccess; // index port access in configuration mode
  logic datAccess; // data port access in configuration mode
  logic isGlobal; // indexed register is a global one
  logic isActivate; // indexed register is the activate byte

  // no access is claimed while held in either reset or blocked
  assign take = ioStrobe && !hostBlocked && !hostRstActive;
  assign dataAddr = cfgBase + `CPKD_DATA_OFS;
  assign hitBase = (ioAddr == cfgBase);
  assign hitData = (ioAddr == dataAddr);
  assign keyWrite = take && hitBase && ioWrite;
  assign idxAccess = take && hitBase && (cfgMode == CPKD_CFG);
  assign datAccess = take && hitData && (cfgMode == CPKD_CFG);
  assign isGlobal = (index_reg < `CPKD_IDX_LD_FIRST);
  assign isActivate = (index_reg == `CPKD_IDX_ACTIVATE);

  // ****************************************
  // key state machine
  // ****************************************
  // configuration port writes are the only way into configuration mode; a host reset also leaves it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfgMode <= CPKD_RUN;
    end else if (hostRstActive) begin
      cfgMode <= CPKD_RUN;
    end else if (keyWrite) begin
      case (cfgMode)
        CPKD_RUN: begin
          // anything but the entry key is dropped
          if (ioWdata == `CPKD_KEY_ENTER) begin
            cfgMode <= CPKD_CFG;
          end
        end
        CPKD_CFG: begin
          // in this mode the base port is also the index port
          if (ioWdata == `CPKD_KEY_EXIT) begin
            cfgMode <= CPKD_RUN;
          end
        end
        default: begin
          cfgMode <= CPKD_RUN;
        end
      endcase
    end
  end

  // ****************************************
  // index port
  // ****************************************
  // the entry key is not written here; the exit key does land as an index,
  // which is harmless since the next entry sees a fresh index write
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      index_reg <= 8'h00;
    end else if (hostRstActive) begin
      index_reg <= 8'h00;
    end else if (idxAccess && ioWrite) begin
      index_reg <= ioWdata;
    end
  end

  // ****************************************
  // global registers
  // ****************************************
  logic dataWrite; // data port write in configuration mode
  logic softReset; // control write with soft reset bit set

  assign dataWrite = datAccess && ioWrite;
  assign softReset = dataWrite && (index_reg == `CPKD_IDX_CTRL) &&
                     ioWdata[`CPKD_CTRL_SOFT_BIT];

  // bank select, cleared by every reset including soft reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ldSelect <= `CPKD_LDSEL_RST;
    end else if (hostRstActive || softReset) begin
      ldSelect <= `CPKD_LDSEL_RST;
    end else if (dataWrite && index_reg == `CPKD_IDX_LDSEL) begin
      ldSelect <= ioWdata;
    end
  end

  // relocatable base; new value decodes from the next cycle on
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfgBase <= `CPKD_BASE_STRAP0;
    end else if (strapTake) begin
      cfgBase <= strapSync ? `CPKD_BASE_STRAP1 : `CPKD_BASE_STRAP0;
    end else if (dataWrite && index_reg == `CPKD_IDX_BASE_LO) begin
      cfgBase[7:0] <= ioWdata;
    end else if (dataWrite && index_reg == `CPKD_IDX_BASE_HI) begin
      cfgBase[15:8] <= ioWdata;
    end
  end

  // ****************************************
  // per device activate bits
  // ****************************************
  // held in flops rather than the store so that reset disables all
  genvar ld;
  generate
    for (ld = 0; ld < `CPKD_LD_COUNT; ld++) begin : g_act
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          ldActive[ld] <= 1'b0;
        end else if (hostRstActive || softReset) begin
          ldActive[ld] <= 1'b0;
        end else if (dataWrite && isActivate && ldSelect == 8'(ld)) begin
          ldActive[ld] <= ioWdata[0];
        end
      end
    end
  endgenerate

  // ****************************************
  // banked register store
  // ****************************************
  logic memWrite; // data write to a banked register
  logic [10:0] memAddr; // bank and index
  logic [7:0] memRdata; // registered store output

  // only the low three bank bits address the store
  assign memWrite = dataWrite && !isGlobal && !isActivate;
  assign memAddr = {ldSelect[2:0], index_reg};

  cpkd_cfg_mem u_mem (
    .clk(clk),
    .reset_n(reset_n),
    .memWrite(memWrite),
    .memAddr(memAddr),
    .memWdata(ioWdata),
    .memRdata(memRdata)
  );

  // ****************************************
  // read value of a global or flop register
  // ****************************************
  logic [7:0] heldValue; // value known in the accept cycle

  always_comb begin
    heldValue = 8'h00;
    if (hitBase) begin
      heldValue = index_reg;
    end else begin
      case (index_reg)
        `CPKD_IDX_LDSEL: heldValue = ldSelect;
        `CPKD_IDX_DEVID: heldValue = `CPKD_DEVID_VAL;
        `CPKD_IDX_DEVREV: heldValue = `CPKD_DEVREV_VAL;
        `CPKD_IDX_BASE_LO: heldValue = cfgBase[7:0];
        `CPKD_IDX_BASE_HI: heldValue = cfgBase[15:8];
        `CPKD_IDX_ACTIVATE: heldValue = {7'h00, ldActive[ldSelect[2:0]]};
        // other globals, including control, read as zero
        default: heldValue = 8'h00;
      endcase
    end
  end

  // ****************************************
  // answer pipeline
  // ****************************************
  logic ackStage_reg; // accepted access waiting for its answer
  cpkd_src_t srcStage_reg; // where the answer data comes from
  logic [7:0] heldStage_reg; // captured flop value

  // one stage lets the store read complete; all answers share it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ackStage_reg <= 1'b0;
      srcStage_reg <= CPKD_SRC_NONE;
      heldStage_reg <= 8'h00;
    end else begin
      ackStage_reg <= keyWrite || idxAccess || datAccess;
      heldStage_reg <= heldValue;
      if (datAccess && !ioWrite && !isGlobal && !isActivate) begin
        srcStage_reg <= CPKD_SRC_MEM;
      end else if ((idxAccess || datAccess) && !ioWrite) begin
        srcStage_reg <= CPKD_SRC_HELD;
      end else begin
        srcStage_reg <= CPKD_SRC_NONE;
      end
    end
  end

  // answer flops; write answers carry zero data
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ioAck <= 1'b0;
      ioRdata <= 8'h00;
    end else begin
      ioAck <= ackStage_reg;
      case (srcStage_reg)
        CPKD_SRC_MEM: ioRdata <= memRdata;
        CPKD_SRC_HELD: ioRdata <= heldStage_reg;
        CPKD_SRC_NONE: ioRdata <= 8'h00;
        default: ioRdata <= 8'h00;
      endcase
    end
  end

  // the host ordering of key, accesses and exit key is assumed;
  // accesses before the key other than base port writes are simply not claimed
endmodule // cpkd_top

//--- testbench/cpkd_top_props.sv
// concurrent checks on the ports of the key decoder
`timescale 1ns/10ps
module cpkd_top_props import cpkd_pkg::*; #(
  parameter int BLOCK_CYCLES = 20
) (
  // clock and resets
  input wire logic clk,
  input wire logic reset_n,
  input wire logic host_bus_reset_n,
  input wire logic strapSelect,
  // host cycle and answer
  input wire logic ioStrobe,
  input wire logic ioWrite,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWdata,
  input wire logic ioAck,
  input wire logic [7:0] ioRdata,
  // status
  input wire cpkd_pkg::cpkd_state_t cfgMode,
  input wire logic hostBlocked,
  input wire logic [15:0] cfgBase,
  input wire logic [7:0] ldSelect,
  input wire logic [7:0] ldActive
);
  // ****************************************
  // helper logic
  // ****************************************
  logic [1:0] hostUpCnt; // cycles of host reset high, the pin goes through a synchroniser
  always_ff @(posedge clk) begin
    if (!reset_n || !host_bus_reset_n) hostUpCnt <= 2'h0;
    else if (hostUpCnt != 2'h3) hostUpCnt <= hostUpCnt + 2'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a claimable base write, seen at the taking edge
  sequence baseWr;
    ioStrobe && ioWrite && !hostBlocked && hostUpCnt == 2'h3 && ioAddr == cfgBase;
  endsequence
  sequence ackTwo;
    ##2 ioAck;
  endsequence
  // ****************************************
  // assertions
  // ****************************************
  base_write_ack_a: assert property (baseWr |-> ackTwo) else $error("base write not acked");
  enter_key_a: assert property (baseWr and (ioWdata == 8'h55 && cfgMode == CPKD_RUN)
    |=> cfgMode == CPKD_CFG) else $error("entry key ignored");
  exit_key_a: assert property (baseWr and (ioWdata == 8'haa && cfgMode == CPKD_CFG)
    |=> cfgMode == CPKD_RUN) else $error("exit key ignored");
  run_other_a: assert property (baseWr and (ioWdata != 8'h55 && cfgMode == CPKD_RUN)
    |=> cfgMode == CPKD_RUN) else $error("run mode left by other value");
  run_refuse_a: assert property (ioStrobe && cfgMode == CPKD_RUN
    && !(ioWrite && ioAddr == cfgBase) |-> ##2 !ioAck) else $error("run access claimed");
  data_port_ack_a: assert property (ioStrobe && !hostBlocked && hostUpCnt == 2'h3
    && cfgMode == CPKD_CFG && ioAddr == cfgBase + 16'h0001 |-> ackTwo) else $error("data port");
  blocked_refuse_a: assert property (ioStrobe && hostBlocked |-> ##2 !ioAck)
    else $error("access claimed while blocked");
  host_reset_a: assert property (!host_bus_reset_n [*5] |-> cfgMode == CPKD_RUN
    && ldSelect == 8'h00 && ldActive == 8'h00) else $error("host reset did not clear");
  power_reset_a: assert property ($rose(reset_n) |-> cfgMode == CPKD_RUN
    && ldActive == 8'h00 && hostBlocked [*8]) else $error("power reset state");
  strap_base_a: assert property ($fell(hostBlocked)
    |-> cfgBase == (strapSelect ? 16'h004e : 16'h002e)) else $error("strap base wrong");
endmodule // cpkd_top_props

//--- testbench/cpkd_host_model.sv
// host side model issuing decoded i/o cycles
`timescale 1ns/10ps
module cpkd_host_model (
  // clock
  input wire logic clk,
  // request
  output logic ioStrobe,
  output logic ioWrite,
  output logic [15:0] ioAddr,
  output logic [7:0] ioWdata,
  // answer
  input wire logic ioAck,
  input wire logic [7:0] ioRdata
);
  // idle bus at time zero
  initial begin
    ioStrobe = 1'b0;
    ioWrite = 1'b0;
    ioAddr = 16'h0000;
    ioWdata = 8'h00;
  end
  // one byte cycle; the caller keeps entry, access, exit order
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d,
                    output logic ack, output logic [7:0] rd);
    @(posedge clk);
    ioStrobe <= 1'b1;
    ioWrite <= w;
    ioAddr <= a;
    ioWdata <= d;
    @(posedge clk);
    // released lines show the inverse so stale values never pass
    ioStrobe <= 1'b0;
    ioWrite <= ~w;
    ioAddr <= ~a;
    ioWdata <= ~d;
    ack = 1'b0;
    rd = 8'h00;
    // answer comes two cycles after taking; one a cycle late still counts, a missing one shows as no ack
    repeat (3) begin
      @(posedge clk);
      if (ioAck === 1'b1 && !ack) begin
        ack = 1'b1;
        rd = ioRdata;
      end
    end
  endtask
endmodule // cpkd_host_model

//--- testbench/config_port_key_decoder_test.sv
// self-checking bench of the key decoder
`timescale 1ns/10ps
`include "cpkd_map.svh"
module config_port_key_decoder_test;
  import cpkd_pkg::*;
  localparam int BLOCK_CYCLES = 20; // shortened power-on block
  // ****************************************
  // signals
  // ****************************************
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic host_bus_reset_n = 1'b1;
  logic strapSelect = 1'b0; // pull-down: base 0x002e
  logic ioStrobe, ioWrite, ioAck, hostBlocked, ack;
  logic [15:0] ioAddr, cfgBase;
  logic [7:0] ioWdata, ioRdata, ldSelect, ldActive, rd;
  cpkd_state_t cfgMode;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  // one row: write flag, address, data, expected ack, read byte, mode after
  typedef struct {logic w; logic [15:0] a; logic [7:0] d; logic k; logic [7:0] r; logic m;} cpkd_row_t;
  cpkd_row_t rows [21] = '{
    '{0, 'h2e, 0, 0, 0, 0}, '{1, 'h2f, 'h55, 0, 0, 0},
    '{1, 'h2e, 'h12, 1, 0, 0}, '{1, 'h2e, 'h55, 1, 0, 1},
    '{1, 'h2e, 'h20, 1, 0, 1}, '{0, 'h2f, 0, 1, `CPKD_DEVID_VAL, 1},
    '{0, 'h2e, 0, 1, 'h20, 1}, '{1, 'h2e, 'h07, 1, 0, 1},
    '{1, 'h2f, 'h03, 1, 0, 1}, '{0, 'h2f, 0, 1, 'h03, 1},
    '{1, 'h2e, 'hf0, 1, 0, 1}, '{1, 'h2f, 'ha5, 1, 0, 1}, '{0, 'h2f, 0, 1, 'ha5, 1},
    '{1, 'h2e, 'h30, 1, 0, 1}, '{1, 'h2f, 'h01, 1, 0, 1},
    '{1, 'h2e, 'h26, 1, 0, 1}, '{1, 'h2f, 'h60, 1, 0, 1},
    '{1, 'h2e, 'haa, 0, 0, 1}, '{1, 'h60, 'haa, 1, 0, 0},
    '{0, 'h61, 0, 0, 0, 0}, '{1, 'h60, 'h55, 1, 0, 1}};
  // ****************************************
  // clock, instances, timeout
  // ****************************************
  always #10 clk = ~clk;
  cpkd_top #(.BLOCK_CYCLES(BLOCK_CYCLES)) u_cpkd_top (.clk(clk), .reset_n(reset_n),
    .host_bus_reset_n(host_bus_reset_n), .strapSelect(strapSelect), .ioStrobe(ioStrobe),
    .ioWrite(ioWrite), .ioAddr(ioAddr), .ioWdata(ioWdata), .ioAck(ioAck), .ioRdata(ioRdata),
    .cfgMode(cfgMode), .hostBlocked(hostBlocked), .cfgBase(cfgBase), .ldSelect(ldSelect),
    .ldActive(ldActive));
  cpkd_host_model u_cpkd_host_model (.clk(clk), .ioStrobe(ioStrobe), .ioWrite(ioWrite),
    .ioAddr(ioAddr), .ioWdata(ioWdata), .ioAck(ioAck), .ioRdata(ioRdata));
  // a hang ends the run as a failure
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      complete_run();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    // early access lands inside the power-on block and must go unanswered
    u_cpkd_host_model.io(1'b1, 16'h002e, 8'h55, ack, rd);
    check({15'h0, ack}, 16'h0000);
    check({15'h0, cfgMode}, 16'h0000);
    check({15'h0, hostBlocked}, 16'h0001);
    for (int i = 0; i < 100 && hostBlocked !== 1'b0; i++) @(posedge clk);
    check(cfgBase, 16'h002e);
    // table of ordinary cycles
    foreach (rows[i]) begin
      u_cpkd_host_model.io(rows[i].w, rows[i].a, rows[i].d, ack, rd);
      check({15'h0, ack}, {15'h0, rows[i].k});
      check({15'h0, cfgMode}, {15'h0, rows[i].m});
      if (!rows[i].w && rows[i].k) check({8'h0, rd}, {8'h0, rows[i].r});
    end
    check({8'h0, ldSelect}, 16'h0003);
    check({8'h0, ldActive}, 16'h0008);
    check(cfgBase, 16'h0060);
    // host bus reset in configuration mode with strap now high
    @(posedge clk);
    strapSelect <= 1'b1;
    @(posedge clk);
    host_bus_reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    host_bus_reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    check({15'h0, cfgMode}, 16'h0000);
    check({8'h0, ldActive}, 16'h0000);
    check(cfgBase, 16'h004e);
    u_cpkd_host_model.io(1'b1, 16'h004e, 8'h55, ack, rd);
    check({15'h0, ack}, 16'h0001);
    check({15'h0, cfgMode}, 16'h0001);
    // bank 5 activated, then a soft reset through the control register clears it
    u_cpkd_host_model.io(1'b1, 16'h004e, `CPKD_IDX_LDSEL, ack, rd);
    u_cpkd_host_model.io(1'b1, 16'h004f, 8'h05, ack, rd);
    u_cpkd_host_model.io(1'b1, 16'h004e, `CPKD_IDX_ACTIVATE, ack, rd);
    u_cpkd_host_model.io(1'b1, 16'h004f, 8'h01, ack, rd);
    check({8'h0, ldActive}, 16'h0020);
    u_cpkd_host_model.io(1'b1, 16'h004e, `CPKD_IDX_CTRL, ack, rd);
    u_cpkd_host_model.io(1'b1, 16'h004f, 8'h01, ack, rd);
    check({ldSelect, ldActive}, 16'h0000);
    // revision read, then the high base byte moves the ports
    u_cpkd_host_model.io(1'b1, 16'h004e, `CPKD_IDX_DEVREV, ack, rd);
    u_cpkd_host_model.io(1'b0, 16'h004f, 8'h00, ack, rd);
    check({15'h0, ack}, 16'h0001);
    check({8'h0, rd}, {8'h0, `CPKD_DEVREV_VAL});
    u_cpkd_host_model.io(1'b1, 16'h004e, `CPKD_IDX_BASE_HI, ack, rd);
    u_cpkd_host_model.io(1'b1, 16'h004f, 8'h01, ack, rd);
    check(cfgBase, 16'h014e);
    u_cpkd_host_model.io(1'b1, 16'h014e, `CPKD_KEY_EXIT, ack, rd);
    check({15'h0, ack}, 16'h0001);
    check({15'h0, cfgMode}, 16'h0000);
    complete_run();
  end
endmodule // config_port_key_decoder_test
bind cpkd_top cpkd_top_props #(.BLOCK_CYCLES(BLOCK_CYCLES)) u_cpkd_top_props (.clk(clk),
  .reset_n(reset_n), .host_bus_reset_n(host_bus_reset_n), .strapSelect(strapSelect),
  .ioStrobe(ioStrobe), .ioWrite(ioWrite), .ioAddr(ioAddr), .ioWdata(ioWdata), .ioAck(ioAck),
  .ioRdata(ioRdata), .cfgMode(cfgMode), .hostBlocked(hostBlocked), .cfgBase(cfgBase),
  .ldSelect(ldSelect), .ldActive(ldActive));
